// ==== air_host_model.sv ====
// Purpose: Host software model driving the routing register port.
// Assumes: One strobe per access, changed 1 ns after MCLK rises.
// Notes: Write data is inverted once the strobe drops.
`timescale 1ns/1ps
module air_host_model (
	input wire logic MCLK,
	input wire logic [7:0] REG_RDATA,
	output logic [6:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WR,
	output logic REG_RD
);
	initial begin
		REG_ADDR = 7'h00;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge MCLK);
		#1;
		REG_ADDR = a;
		REG_WDATA = (a == 7'h14) ? {5'b0_1111, d[2], 2'b00} : d;
		REG_WR = 1'b1;
		@(posedge MCLK);
		#1;
		REG_WR = 1'b0;
		REG_WDATA = ~REG_WDATA;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge MCLK);
		#1;
		REG_ADDR = a;
		REG_RD = 1'b1;
		@(posedge MCLK);
		#1;
		REG_RD = 1'b0;
		d = REG_RDATA;
	endtask
endmodule // air_host_model

// ==== air_input_routing.sv ====
// Purpose: Routing, power and soft-step control registers for the record mixers.
// Assumes: Register port is driven by the serial control bus logic on MCLK.
// Notes: FS_TICK is a one-cycle sample-rate enable from the clock divider.
`timescale 1ns/1ps
module air_input_routing
	import air_pkg::*;
(
	input wire logic MCLK,
	input wire logic RST,
	input wire logic [6:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic FS_TICK,
	output logic [7:0] REG_RDATA,
	output logic SP_LEFT_TO_RIGHT_CONNECT,
	output logic [4:0] SP_LEFT_TO_RIGHT_ATTEN,
	output logic SP_RIGHT_TO_RIGHT_CONNECT,
	output logic [4:0] SP_RIGHT_TO_RIGHT_ATTEN,
	output logic FP_LEFT_TO_LEFT_CONNECT,
	output logic [4:0] FP_LEFT_TO_LEFT_ATTEN,
	output logic FP_LEFT_DIFFERENTIAL,
	output logic LEFT_CHANNEL_POWER,
	output logic LEFT_STEP_ENABLE,
	output logic LEFT_STEP_PULSE,
	output logic LEFT_CM_TIE
);

	////////////////////////////////////////////////////////////////////////////////
	// Address decode

	logic wr_sp;
	logic wr_fp;
	logic wr_cm;
	logic [3:0] sp_left_code;
	logic [3:0] sp_right_code;
	logic [3:0] fp_left_code;
	logic diff_ff;
	logic power_ff;
	logic [1:0] step_mode_ff;
	logic cm_tie_ff;
	logic step_phase_ff;
	logic step_pulse_ff;
	logic step_on_ff;
	logic [7:0] rdata_q_ff;
	logic [7:0] sp_read;
	logic [7:0] fp_read;
	logic [7:0] cm_read;
	logic [7:0] nxt_rdata;
	logic nxt_step_pulse;
	logic nxt_step_phase;
	logic step_on;
	air_step_t step_mode;

	// RULE13 register 18 map
	assign wr_sp = REG_WR && (REG_ADDR == ADDR_SECOND_PAIR_RIGHT);
	assign wr_fp = REG_WR && (REG_ADDR == ADDR_FIRST_PAIR_LEFT);
	assign wr_cm = REG_WR && (REG_ADDR == ADDR_COMMON_MODE_TIE);

	////////////////////////////////////////////////////////////////////////////////
	// Level fields

	// RULE5 upper nibble left input
	air_level_field u_sp_left (
		.clk(MCLK),
		.rst(RST),
		.wr_en(wr_sp),
		.code_in(REG_WDATA[SP_LEFT_HI:SP_LEFT_LO]),
		.code_ff(sp_left_code),
		.connect_ff(SP_LEFT_TO_RIGHT_CONNECT),
		.atten_ff(SP_LEFT_TO_RIGHT_ATTEN)
	);

	// RULE5 lower nibble right input
	air_level_field u_sp_right (
		.clk(MCLK),
		.rst(RST),
		.wr_en(wr_sp),
		.code_in(REG_WDATA[SP_RIGHT_HI:SP_RIGHT_LO]),
		.code_ff(sp_right_code),
		.connect_ff(SP_RIGHT_TO_RIGHT_CONNECT),
		.atten_ff(SP_RIGHT_TO_RIGHT_ATTEN)
	);

	// RULE8 bits 6 to 3
	air_level_field u_fp_left (
		.clk(MCLK),
		.rst(RST),
		.wr_en(wr_fp),
		.code_in(REG_WDATA[FP_LEVEL_HI:FP_LEVEL_LO]),
		.code_ff(fp_left_code),
		.connect_ff(FP_LEFT_TO_LEFT_CONNECT),
		.atten_ff(FP_LEFT_TO_LEFT_ATTEN)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Control bits

	always_ff @(posedge MCLK) begin
		if (RST) begin
			diff_ff <= 1'b0;
			power_ff <= 1'b0;
			step_mode_ff <= 2'h0;
		end else if (wr_fp) begin
			// RULE6 differential select
			diff_ff <= REG_WDATA[FP_DIFF_BIT];
			// RULE9 left power
			power_ff <= REG_WDATA[FP_POWER_BIT];
			step_mode_ff <= REG_WDATA[FP_STEP_HI:FP_STEP_LO];
		end
	end

	// Only bit 2 is stored; reserved bits of the tie register are fixed on read
	always_ff @(posedge MCLK) begin
		// RULE11 common-mode tie
		if (RST) begin
			cm_tie_ff <= 1'b0;
		end else if (wr_cm) begin
			cm_tie_ff <= REG_WDATA[CM_TIE_BIT];
		end
	end

	assign FP_LEFT_DIFFERENTIAL = diff_ff;
	assign LEFT_CHANNEL_POWER = power_ff;
	assign LEFT_CM_TIE = cm_tie_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Soft-step pacing

	assign step_mode = air_step_t'(step_mode_ff);
	assign step_on = (step_mode == AIR_STEP_EVERY_FS) || (step_mode == AIR_STEP_EVERY_TWO_FS);
	assign LEFT_STEP_ENABLE = step_on_ff;

	// RULE10 step rate select
	always_comb begin
		nxt_step_pulse = 1'b0;
		nxt_step_phase = step_phase_ff;
		case (step_mode)
			AIR_STEP_EVERY_FS: begin
				nxt_step_pulse = FS_TICK;
				nxt_step_phase = 1'b0;
			end
			AIR_STEP_EVERY_TWO_FS: begin
				nxt_step_pulse = FS_TICK && step_phase_ff;
				nxt_step_phase = FS_TICK ? !step_phase_ff : step_phase_ff;
			end
			default: begin
				nxt_step_pulse = 1'b0;
				nxt_step_phase = 1'b0;
			end
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			step_phase_ff <= 1'b0;
			step_pulse_ff <= 1'b0;
			step_on_ff <= 1'b1;
		end else begin
			step_phase_ff <= nxt_step_phase;
			step_pulse_ff <= nxt_step_pulse;
			step_on_ff <= step_on;
		end
	end

	assign LEFT_STEP_PULSE = step_pulse_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Read-back

	// RULE14 read written fields
	assign sp_read = {sp_left_code, sp_right_code};
	assign fp_read = {diff_ff, fp_left_code, power_ff, step_mode_ff};
	assign cm_read = CM_RESERVED_READ | {5'h00, cm_tie_ff, 2'h0};
	assign nxt_rdata = (REG_ADDR == ADDR_SECOND_PAIR_RIGHT) ? sp_read :
		(REG_ADDR == ADDR_FIRST_PAIR_LEFT) ? fp_read :
		(REG_ADDR == ADDR_COMMON_MODE_TIE) ? cm_read : READ_UNMAPPED;

	// Read data holds until the next read so a slow bus can sample it late
	always_ff @(posedge MCLK) begin
		if (RST) begin
			rdata_q_ff <= READ_UNMAPPED;
		end else if (REG_RD) begin
			rdata_q_ff <= nxt_rdata;
		end
	end

	assign REG_RDATA = rdata_q_ff;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_power_follows_write: assert property (@(posedge MCLK) disable iff (RST)
		wr_fp |=> (LEFT_CHANNEL_POWER == $past(REG_WDATA[2]))) // RULE9
		else $error("left power does not follow written bit");
	a_power_reset_off: assert property (@(posedge MCLK) RST |=> !LEFT_CHANNEL_POWER && !LEFT_CM_TIE) // RULE9
		else $error("power or tie not cleared by reset");
	a_diff_follows_write: assert property (@(posedge MCLK) disable iff (RST)
		wr_fp |=> (FP_LEFT_DIFFERENTIAL == $past(REG_WDATA[7]))) // RULE6
		else $error("differential select does not follow bit 7");
	a_cm_read_fixed: assert property (@(posedge MCLK) disable iff (RST)
		REG_RD && (REG_ADDR == 7'h14) |=> (REG_RDATA[7:3] == 5'h0F) && (REG_RDATA[1:0] == 2'h0)
		&& (REG_RDATA[2] == $past(LEFT_CM_TIE))) // RULE11
		else $error("common-mode register read-back wrong");
	a_step_every_fs: assert property (@(posedge MCLK) disable iff (RST)
		FS_TICK && (step_mode_ff == 2'h0) |=> LEFT_STEP_PULSE) // RULE10
		else $error("no step on sample tick in every-sample mode");
	a_step_two_fs: assert property (@(posedge MCLK) disable iff (RST)
		LEFT_STEP_PULSE && (step_mode_ff == 2'h1) && $stable(step_mode_ff)
		|-> !$past(LEFT_STEP_PULSE) && $past(step_phase_ff) && !step_phase_ff) // RULE10
		else $error("two-sample stepping fired on consecutive phases");
	a_step_disabled: assert property (@(posedge MCLK) disable iff (RST)
		step_mode_ff[1] && $past(step_mode_ff[1]) |-> !LEFT_STEP_PULSE) // RULE10
		else $error("step pulse while soft-stepping disabled");
	a_sp_read_nibbles: assert property (@(posedge MCLK) disable iff (RST)
		wr_sp ##1 !wr_sp ##1 (REG_RD && (REG_ADDR == 7'h12) && !REG_WR)
		|=> (REG_RDATA == $past(REG_WDATA, 3))) // RULE5
		else $error("register 18 read-back differs from last write");

endmodule // air_input_routing

// ==== air_input_routing_tb_top.sv ====
// Purpose: Self-check of the routing register set against a bench model.
// Assumes: Host model drives the register port; bench drives FS_TICK.
// Notes: Level codes limited to 0..8 and 15.
`timescale 1ns/1ps
module air_input_routing_tb_top;
	logic MCLK = 1'b0;
	logic RST = 1'b1;
	logic FS_TICK = 1'b0;
	logic [6:0] a;
	logic [7:0] wd, rd;
	logic [7:0] rdata;
	logic spl_c, spr_c, fp_c, fp_d, pwr, step_en, step_p, cm;
	logic [4:0] spl_a, spr_a, fp_a;
	logic wr_s, rd_s;
	int err_count = 0;
	int comparisons = 0;
	int cycles = 0;
	int pulses = 0;
	always #20 MCLK = ~MCLK;
	air_host_model i_host (.MCLK(MCLK), .REG_RDATA(rdata), .REG_ADDR(a), .REG_WDATA(wd),
		.REG_WR(wr_s), .REG_RD(rd_s));
	air_input_routing i_dut (.MCLK(MCLK), .RST(RST), .REG_ADDR(a), .REG_WDATA(wd),
		.REG_WR(wr_s), .REG_RD(rd_s), .FS_TICK(FS_TICK), .REG_RDATA(rdata),
		.SP_LEFT_TO_RIGHT_CONNECT(spl_c), .SP_LEFT_TO_RIGHT_ATTEN(spl_a),
		.SP_RIGHT_TO_RIGHT_CONNECT(spr_c), .SP_RIGHT_TO_RIGHT_ATTEN(spr_a),
		.FP_LEFT_TO_LEFT_CONNECT(fp_c), .FP_LEFT_TO_LEFT_ATTEN(fp_a),
		.FP_LEFT_DIFFERENTIAL(fp_d), .LEFT_CHANNEL_POWER(pwr), .LEFT_STEP_ENABLE(step_en),
		.LEFT_STEP_PULSE(step_p), .LEFT_CM_TIE(cm));
	////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge MCLK) begin
		cycles++;
		if (step_p === 1'b1)
			pulses++;
		if (cycles == 6000) begin
			err_count++;
			wrap_up();
		end
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Model: connect flag on top of attenuation in half-dB units
	function automatic logic [7:0] lvl(input int c);
		return (c <= 8) ? {3'b001, 5'(c * 3)} : 8'h00;
	endfunction
	task automatic rdchk(input logic [6:0] ad, input logic [7:0] exp);
		i_host.rd(ad, rd);
		chk("read", exp, rd);
	endtask
	task automatic step_test(input int m);
		int p0;
		i_host.wr(7'h13, {6'b0111_10, 2'(m)});
		repeat (2) @(posedge MCLK);
		#1;
		chk("step_en", {7'h00, 1'(m < 2)}, {7'h00, step_en});
		p0 = pulses;
		repeat (6) begin
			FS_TICK = 1'b1;
			@(posedge MCLK);
			#1;
			FS_TICK = 1'b0;
			repeat (2) @(posedge MCLK);
			#1;
		end
		chk("pulses", 8'((m == 0) ? 6 : (m == 1) ? 3 : 0), 8'(pulses - p0));
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		int c1, c2, c3, d, p;
		void'($urandom(79));
		repeat (16) @(posedge MCLK);
		#1;
		RST = 1'b0;
		// reset state of all registers, an unmapped read and the outputs
		rdchk(7'h12, 8'hFF);
		rdchk(7'h13, 8'h78);
		rdchk(7'h14, 8'h78);
		rdchk(7'h15, 8'h00);
		chk("reset", 8'h04, {spl_c, spr_c, fp_c, fp_d, pwr, step_en, cm, step_p});
		$display("reset test done");
		for (int i = 0; i < 10; i++) begin
			// only valid or disconnect codes are written
			c1 = i;
			c2 = $urandom % 10;
			c3 = $urandom % 10;
			c1 = (c1 == 9) ? 15 : c1;
			c2 = (c2 == 9) ? 15 : c2;
			c3 = (c3 == 9) ? 15 : c3;
			d = $urandom % 2;
			p = $urandom % 2;
			i_host.wr(7'h12, {4'(c1), 4'(c2)});
			chk("sp_left", lvl(c1), {3'b001 & {2'b00, spl_c}, spl_a});
			chk("sp_right", lvl(c2), {2'b00, spr_c, spr_a});
			rdchk(7'h12, {4'(c1), 4'(c2)});
			// only this register carries the differential choice here
			i_host.wr(7'h13, {1'(d), 4'(c3), 1'(p), 2'b11});
			chk("fp_left", lvl(c3), {2'b00, fp_c, fp_a});
			chk("fp_mode", {6'h00, 1'(d), 1'(p)}, {6'h00, fp_d, pwr});
			rdchk(7'h13, {1'(d), 4'(c3), 1'(p), 2'b11});
		end
		$display("routing test done");
		i_host.wr(7'h14, 8'hFF);
		chk("cm_tie", 8'h01, {7'h00, cm});
		rdchk(7'h14, 8'h7C);
		i_host.wr(7'h14, 8'h00);
		chk("cm_tie", 8'h00, {7'h00, cm});
		$display("common mode test done");
		for (int m = 0; m < 4; m++)
			step_test(m);
		step_test(1);
		$display("soft step test done");
		wrap_up();
	end
endmodule // air_input_routing_tb_top

// ==== air_level_field.sv ====
// Purpose: One 4-bit input level field with its decoded connect and attenuation.
// Assumes: Written from the register decode in the same clock domain.
// Notes: Decode is done at write time so outputs come straight from flops.
`timescale 1ns/1ps
module air_level_field
	import air_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [3:0] code_in,
	output logic [3:0] code_ff,
	output logic connect_ff,
	output logic [4:0] atten_ff
);

	logic nxt_connect;
	logic [5:0] scaled;
	logic [4:0] nxt_atten;

	// RULE4 connect on code
	assign nxt_connect = (code_in <= LEVEL_MAX_VALID);
	// RULE1 1.5 dB steps
	assign scaled = {2'b00, code_in} * HALF_DB_PER_CODE;
	// Reserved codes leave the route open, so their scaled value is never shown
	assign nxt_atten = nxt_connect ? scaled[4:0] : 5'h00;

	always_ff @(posedge clk) begin
		// RULE2 reset disconnected
		if (rst) begin
			code_ff <= LEVEL_RESET;
			connect_ff <= 1'b0;
			atten_ff <= 5'h00;
		end else if (wr_en) begin
			code_ff <= code_in;
			connect_ff <= nxt_connect;
			atten_ff <= nxt_atten;
		end
	end

	a_field_reset_open: assert property (@(posedge clk) rst |=> (code_ff == LEVEL_RESET) && !connect_ff) // RULE2
		else $error("level field not disconnected after reset");
	a_field_atten_scale: assert property (@(posedge clk) disable iff (rst)
		wr_en && (code_in <= 4'h8) |=> connect_ff && (atten_ff == 5'($past(code_in)) * 5'd3)) // RULE1
		else $error("attenuation does not match written level code");
	a_field_open_code: assert property (@(posedge clk) disable iff (rst)
		wr_en && (code_in == 4'hF) |=> !connect_ff && (atten_ff == 5'h00)) // RULE2
		else $error("disconnect code left input connected");
	a_field_hold: assert property (@(posedge clk) disable iff (rst)
		!wr_en |=> $stable(code_ff) && $stable(connect_ff)) // RULE14
		else $error("level field changed without a write");

endmodule // air_level_field

// ==== air_pkg.sv ====
// Purpose: Constants for the record-channel input routing register set.
// Assumes: Page 0 register map, 8-bit registers, one register clock.
// Notes: Attenuation is reported in 0.5 dB units, so code n means 3n half-dB steps.
// Operation
// RULE1 - Level codes 0..8 attenuate 0 dB to -12 dB, 1.5 dB per step.
// RULE2 - Code 1111 disconnects the input; every level field resets to 1111.
// RULE3 - Software never writes reserved level codes 9 through 14.
// RULE4 - Writing a valid code alone connects the input to its mixer.
// RULE5 - Register 18: upper nibble second-pair left, lower nibble second-pair right.
// RULE6 - First-pair left register bit 7: 0 single-ended positive, 1 differential pair.
// RULE7 - Software keeps the differential choice equal in both channels' registers.
// RULE8 - First-pair left register bits 6..3 hold the first-pair left level code.
// RULE9 - First-pair left register bit 2 powers the left record channel; resets to 0.
// RULE10 - Soft-step 00 every sample, 01 every two samples, 1x disabled.
// RULE11 - Common-mode tie register bit 2 ties unselected left inputs to common mode.
// RULE12 - Software writes 01111 and 00 into the tie register reserved bits.
// RULE13 - The right-mixer second-pair register sits at page 0 register 18.
// RULE14 - Settings act right after the write; reads return written fields.
package air_pkg;

	localparam logic [6:0] ADDR_SECOND_PAIR_RIGHT = 7'h12;
	localparam logic [6:0] ADDR_FIRST_PAIR_LEFT = 7'h13;
	localparam logic [6:0] ADDR_COMMON_MODE_TIE = 7'h14;

	localparam int SP_LEFT_HI = 7;
	localparam int SP_LEFT_LO = 4;
	localparam int SP_RIGHT_HI = 3;
	localparam int SP_RIGHT_LO = 0;
	localparam int FP_DIFF_BIT = 7;
	localparam int FP_LEVEL_HI = 6;
	localparam int FP_LEVEL_LO = 3;
	localparam int FP_POWER_BIT = 2;
	localparam int FP_STEP_HI = 1;
	localparam int FP_STEP_LO = 0;
	localparam int CM_TIE_BIT = 2;

	localparam logic [3:0] LEVEL_RESET = 4'hF;
	localparam logic [3:0] LEVEL_DISCONNECT = 4'hF;
	localparam logic [3:0] LEVEL_MAX_VALID = 4'h8;
	localparam logic [5:0] HALF_DB_PER_CODE = 6'h03;
	localparam logic [7:0] CM_RESERVED_READ = 8'h78;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;

	typedef enum logic [1:0] {
		AIR_STEP_EVERY_FS,
		AIR_STEP_EVERY_TWO_FS,
		AIR_STEP_OFF_A,
		AIR_STEP_OFF_B
	} air_step_t;

endpackage
